// ===== hdl/cc_channel.sv
// one capture/compare module of the counter array
`default_nettype none
module cc_channel (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// configuration and shared count
	input wire counter_array_pkg::module_mode_t mode,
	input wire logic active,
	input wire logic [15:0] count,
	input wire logic moved,
	// software writes to the value bytes
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wr_data,
	// module line and results
	input wire logic line_in,
	output logic line_out,
	output logic [15:0] value,
	output logic event_hit
);
	import counter_array_pkg::*;

	logic line_prev_reg;
	logic [7:0] lo_reg;
	logic [7:0] hi_reg;
	logic cap_mode;
	logic cap_now;
	logic match_hit;
	logic pwm_mode;
	logic tog_mode;

	// ========================================
	// mode decode
	assign cap_mode = !mode.match_flag_enable && !mode.toggle_enable &&
		!mode.pulse_width_enable;
	assign cap_now = cap_mode && active && ((mode.rise_capture_enable &&
		line_in && !line_prev_reg) || (mode.fall_capture_enable &&
		!line_in && line_prev_reg));
	// moved marks the first cycle of a new count, so a match fires once
	assign match_hit = moved && mode.compare_enable &&
		count == value;
	assign pwm_mode = mode.compare_enable && mode.pulse_width_enable;
	assign tog_mode = mode.match_flag_enable && mode.toggle_enable;
	assign event_hit = cap_now ||
		(match_hit && mode.match_flag_enable);
	assign value = {hi_reg, lo_reg};

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			line_prev_reg <= 1'b0;
		end else begin
			line_prev_reg <= line_in;
		end
	end

	// ========================================
	// value bytes; a capture beats a software write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lo_reg <= RESET_BYTE;
		end else if (cap_now) begin
			lo_reg <= count[7:0];
		end else if (pwm_mode && moved && count[7:0] == LOW_ZERO) begin
			lo_reg <= hi_reg;
		end else if (wr_lo) begin
			lo_reg <= wr_data;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hi_reg <= RESET_BYTE;
		end else if (cap_now) begin
			hi_reg <= count[15:8];
		end else if (wr_hi) begin
			hi_reg <= wr_data;
		end
	end

	// ========================================
	// line drive
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			line_out <= 1'b0;
		end else if (pwm_mode && moved) begin
			if (count[7:0] == lo_reg) begin
				line_out <= 1'b1;
			end else if (count[7:0] == LOW_ZERO) begin
				line_out <= 1'b0;
			end
		end else if (!pwm_mode && tog_mode && match_hit) begin
			line_out <= !line_out;
		end
	end

	// ========================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_capture_copy: assert property (
		cap_now |=> value == $past(count))
		else $error("capture did not copy the count");
	a_toggle_flip: assert property (
		!pwm_mode && tog_mode && match_hit |=> line_out != $past(line_out))
		else $error("toggle match did not invert the line");
	a_pwm_rise: assert property (
		pwm_mode && moved && count[7:0] == lo_reg |=> line_out)
		else $error("pwm match did not raise the line");
	a_pwm_fall: assert property (
		pwm_mode && moved && count[7:0] == LOW_ZERO && lo_reg != LOW_ZERO
		|=> !line_out)
		else $error("pwm low byte wrap did not lower the line");
	a_pwm_reload: assert property (
		pwm_mode && moved && count[7:0] == LOW_ZERO
		|=> lo_reg == $past(hi_reg))
		else $error("pwm wrap did not reload the low byte");
	a_quiet_module: assert property (
		mode[6:1] == 6'h00 |-> !event_hit ##1 $stable(line_out))
		else $error("unconfigured module was active");

endmodule : cc_channel
`default_nettype wire

// ===== hdl/counter_array.sv
// counter array: shared timebase and counter, five modules, register port
//
// Decided for this implementation: the address map and the strobed register port.
`default_nettype none

// Notes on behaviour
// - one 16-bit counter, five capture/compare modules
// - timebase: clk/12, clk/4, timer0, count falls
// - capture enables choose rising, falling or both
// - capture copies counter into module value
// - capture sets sticky module flag, software clears
// - compare plus match: equality sets module flag
// - toggle mode: each equality inverts the line
// - compare plus pwm enable gives pwm mode
// - pwm: low byte equal drives line high
// - pwm: low byte overflow drives line low
// - pwm: low byte wrap reloads from high
// - low byte read snapshots high byte
// - counter reads never disturb counting
// - counter wrap sets overflow flag, may interrupt
// - overflow flag sticky until software writes zero
// - module enable gates its flag to interrupt
// - interrupts need global and array enables
// - idle suspend clear: runs during idle
// - modules are configured independently
// - idle suspend set: halts during idle
// - run bit starts and stops the counter
module counter_array (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// register port
	input wire counter_array_pkg::reg_req_t req,
	output logic [7:0] rd_data,
	// system context
	input wire logic global_irq_enable,
	input wire logic array_irq_enable,
	input wire logic cpu_idle,
	input wire logic timer0_overflow,
	input wire logic external_count_input,
	// module lines
	input wire logic [4:0] module_io_line_in,
	output logic [4:0] module_io_line_out,
	output logic [4:0] module_io_line_oe,
	// interrupt request
	output logic irq_req
);
	import counter_array_pkg::*;

	// ========================================
	// address decode helpers
	function automatic logic in_bank(input logic [7:0] a,
		input logic [7:0] base);
		return a >= base && a < base + 8'(NUM_MODULES);
	endfunction : in_bank

	function automatic logic [2:0] bank_idx(input logic [7:0] a,
		input logic [7:0] base);
		logic [7:0] d;
		d = a - base;
		return d[2:0];
	endfunction : bank_idx

	// ========================================
	// state
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [7:0] snap_reg;
	logic [3:0] presc_reg;
	logic eci_prev_reg;
	logic moved_reg;
	logic counter_run_reg;
	logic count_overflow_flag_reg;
	logic [4:0] module_event_flag_reg;
	logic idle_suspend_reg;
	logic [1:0] tsel_reg;
	logic overflow_irq_enable_reg;
	module_mode_t mode_reg [NUM_MODULES];
	logic [15:0] value [NUM_MODULES];
	logic [4:0] event_hit;
	logic [4:0] wr_lo;
	logic [4:0] wr_hi;
	logic [4:0] irq_en_mask;
	logic tick_slow;
	logic tick_fast;
	logic eci_fall;
	logic tick_sel;
	logic active;
	logic step;
	logic wr_ctl;
	logic wr_mode;

	assign wr_ctl = req.wr_en && req.addr == ADDR_CTL;
	assign wr_mode = req.wr_en && req.addr == ADDR_MODE;

	// ========================================
	// timebase
	// one divider serves both rates: four divides twelve evenly
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			presc_reg <= 4'h0;
		end else if (presc_reg == DIV_SLOW - 4'h1) begin
			presc_reg <= 4'h0;
		end else begin
			presc_reg <= presc_reg + 4'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			eci_prev_reg <= 1'b0;
		end else begin
			eci_prev_reg <= external_count_input;
		end
	end

	assign tick_slow = presc_reg == DIV_SLOW - 4'h1;
	assign tick_fast = presc_reg[1:0] == 2'(DIV_FAST - 4'h1);
	// edges closer than one cycle apart cannot both be seen
	assign eci_fall = eci_prev_reg && !external_count_input;

	always_comb begin
		unique case (tsel_reg)
			TSEL_DIV12: tick_sel = tick_slow;
			TSEL_DIV4: tick_sel = tick_fast;
			TSEL_T0: tick_sel = timer0_overflow;
			TSEL_EXT: tick_sel = eci_fall;
		endcase
	end

	assign active = !(idle_suspend_reg && cpu_idle);
	assign step = counter_run_reg && active && tick_sel;
	assign count_next = count_reg + 16'h0001;

	// ========================================
	// counter; reads never touch it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_reg <= 16'h0000;
		end else if (step) begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			moved_reg <= 1'b0;
		end else begin
			moved_reg <= step;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			snap_reg <= RESET_BYTE;
		end else if (req.rd_en && req.addr == ADDR_CNT_LO) begin
			snap_reg <= count_reg[15:8];
		end
	end

	// ========================================
	// control and mode registers; hardware set wins over a clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_overflow_flag_reg <= 1'b0;
		end else begin
			count_overflow_flag_reg <= (wr_ctl ? req.wr_data[CTL_OVF_BIT] :
				count_overflow_flag_reg) ||
				(step && count_reg == COUNT_TOP);
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			module_event_flag_reg <= 5'h00;
		end else begin
			module_event_flag_reg <= (wr_ctl ? req.wr_data[4:0] :
				module_event_flag_reg) | event_hit;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			counter_run_reg <= 1'b0;
		end else if (wr_ctl) begin
			counter_run_reg <= req.wr_data[CTL_RUN_BIT];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			idle_suspend_reg <= 1'b0;
			tsel_reg <= TSEL_DIV12;
			overflow_irq_enable_reg <= 1'b0;
		end else if (wr_mode) begin
			idle_suspend_reg <= req.wr_data[MD_IDLE_BIT];
			tsel_reg <= req.wr_data[MD_TSEL_HI:MD_TSEL_LO];
			overflow_irq_enable_reg <= req.wr_data[MD_OVFIE_BIT];
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_MODULES; i++) begin
				mode_reg[i] <= '0;
			end
		end else if (req.wr_en && in_bank(req.addr, ADDR_CPM_BASE)) begin
			mode_reg[bank_idx(req.addr, ADDR_CPM_BASE)] <=
				{1'b0, req.wr_data[6:0]};
		end
	end

	// ========================================
	// modules
	generate
		for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
			assign wr_lo[g] = req.wr_en &&
				req.addr == ADDR_CPL_BASE + 8'(g);
			assign wr_hi[g] = req.wr_en &&
				req.addr == ADDR_CPH_BASE + 8'(g);
			assign irq_en_mask[g] = mode_reg[g].module_irq_enable;
			cc_channel u_channel (
				.sys_clk(sys_clk),
				.rst(rst),
				.mode(mode_reg[g]),
				.active(active),
				.count(count_reg),
				.moved(moved_reg),
				.wr_lo(wr_lo[g]),
				.wr_hi(wr_hi[g]),
				.wr_data(req.wr_data),
				.line_in(module_io_line_in[g]),
				.line_out(module_io_line_out[g]),
				.value(value[g]),
				.event_hit(event_hit[g])
			);
		end
	endgenerate

	// the line is driven only in toggle or pwm modes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			module_io_line_oe <= 5'h00;
		end else begin
			for (int i = 0; i < NUM_MODULES; i++) begin
				module_io_line_oe[i] <= mode_reg[i].compare_enable &&
					(mode_reg[i].pulse_width_enable ||
					(mode_reg[i].match_flag_enable &&
					mode_reg[i].toggle_enable));
			end
		end
	end

	// ========================================
	// interrupt request
	// a flag whose own enable is clear never reaches the request, so
	// software may poll it without taking interrupts
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= global_irq_enable && array_irq_enable &&
				((count_overflow_flag_reg && overflow_irq_enable_reg) ||
				|(module_event_flag_reg & irq_en_mask));
		end
	end

	// ========================================
	// read data, valid the cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_data <= RESET_BYTE;
		end else if (!req.rd_en) begin
			rd_data <= RESET_BYTE;
		end else if (req.addr == ADDR_CTL) begin
			rd_data <= {count_overflow_flag_reg, counter_run_reg, 1'b0,
				module_event_flag_reg};
		end else if (req.addr == ADDR_MODE) begin
			rd_data <= {idle_suspend_reg, 4'h0, tsel_reg,
				overflow_irq_enable_reg};
		end else if (req.addr == ADDR_CNT_LO) begin
			rd_data <= count_reg[7:0];
		end else if (req.addr == ADDR_CNT_HI) begin
			rd_data <= snap_reg;
		end else if (in_bank(req.addr, ADDR_CPM_BASE)) begin
			rd_data <= mode_reg[bank_idx(req.addr, ADDR_CPM_BASE)];
		end else if (in_bank(req.addr, ADDR_CPL_BASE)) begin
			rd_data <= value[bank_idx(req.addr, ADDR_CPL_BASE)][7:0];
		end else if (in_bank(req.addr, ADDR_CPH_BASE)) begin
			rd_data <= value[bank_idx(req.addr, ADDR_CPH_BASE)][15:8];
		end else begin
			rd_data <= RESET_BYTE;
		end
	end

	// ========================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_overflow_flag_set: assert property (
		step && count_reg == COUNT_TOP |=> count_overflow_flag_reg &&
		count_reg == 16'h0000)
		else $error("counter wrap did not set overflow flag");
	a_overflow_flag_hold: assert property (
		count_overflow_flag_reg && !wr_ctl |=> count_overflow_flag_reg)
		else $error("overflow flag cleared without a write");
	a_event_flag_hold: assert property (
		module_event_flag_reg[0] && !wr_ctl |=> module_event_flag_reg[0])
		else $error("module flag cleared without a write");
	a_run_stop: assert property (
		!counter_run_reg |=> $stable(count_reg))
		else $error("counter moved while stopped");
	a_idle_halt: assert property (
		idle_suspend_reg && cpu_idle |=> $stable(count_reg))
		else $error("counter moved while suspended in idle");
	a_snapshot_read: assert property (
		req.rd_en && req.addr == ADDR_CNT_LO ##1
		(req.rd_en && req.addr == ADDR_CNT_HI) |=>
		rd_data == $past(count_reg[15:8], 2))
		else $error("high byte read missed the snapshot");
	a_div_twelve: assert property (
		tick_slow |-> ##12 tick_slow)
		else $error("slow tick spacing not twelve");
	a_div_four: assert property (
		tick_fast |=> !tick_fast [*3] ##1 tick_fast)
		else $error("fast tick spacing not four");
	a_irq_gate: assert property (
		!global_irq_enable || !array_irq_enable |=> !irq_req)
		else $error("interrupt raised while disabled");

endmodule : counter_array
`default_nettype wire

// ===== hdl/counter_array_pkg.sv
// constants, register map and carrier types of the counter array
`default_nettype none
package counter_array_pkg;

	// ========================================
	// geometry
	localparam int NUM_MODULES = 5;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam logic [7:0] LOW_TOP = 8'hFF;
	localparam logic [7:0] LOW_ZERO = 8'h00;

	// ========================================
	// register offsets
	localparam logic [7:0] ADDR_CTL = 8'hD8;
	localparam logic [7:0] ADDR_MODE = 8'hD9;
	localparam logic [7:0] ADDR_CPM_BASE = 8'hDA;
	localparam logic [7:0] ADDR_CNT_LO = 8'hE9;
	localparam logic [7:0] ADDR_CNT_HI = 8'hF9;
	localparam logic [7:0] ADDR_CPL_BASE = 8'hEA;
	localparam logic [7:0] ADDR_CPH_BASE = 8'hFA;

	// ========================================
	// field positions
	localparam int CTL_OVF_BIT = 7;
	localparam int CTL_RUN_BIT = 6;
	localparam int MD_IDLE_BIT = 7;
	localparam int MD_TSEL_HI = 2;
	localparam int MD_TSEL_LO = 1;
	localparam int MD_OVFIE_BIT = 0;

	// ========================================
	// timebase selection and dividers
	localparam logic [1:0] TSEL_DIV12 = 2'h0;
	localparam logic [1:0] TSEL_DIV4 = 2'h1;
	localparam logic [1:0] TSEL_T0 = 2'h2;
	localparam logic [1:0] TSEL_EXT = 2'h3;
	localparam logic [3:0] DIV_SLOW = 4'hC;
	localparam logic [3:0] DIV_FAST = 4'h4;

	// ========================================
	// carriers
	typedef struct packed {
		logic spare;
		logic compare_enable;
		logic rise_capture_enable;
		logic fall_capture_enable;
		logic match_flag_enable;
		logic toggle_enable;
		logic pulse_width_enable;
		logic module_irq_enable;
	} module_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wr_data;
		logic wr_en;
		logic rd_en;
	} reg_req_t;

endpackage : counter_array_pkg
`default_nettype wire

// ===== tb/line_partner.sv
// far-side model: levels on the module lines and external count pulses
`default_nettype none
module line_partner (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// requests from the bench
	input wire logic [4:0] level_cmd,
	input wire logic [7:0] fall_cmd,
	input wire logic fall_go,
	// pins
	output logic [4:0] line_drv,
	output logic ext_line,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] left_reg;
	logic ph_reg;
	// ========================================
	// module lines follow the bench one edge later
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			line_drv <= 5'h00;
		end else begin
			line_drv <= level_cmd;
		end
	end
	// ========================================
	// external count: each level lasts two cycles, twice the shortest level that is seen
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			left_reg <= 9'h000;
			ph_reg <= 1'b0;
			ext_line <= 1'b1;
		end else if (fall_go) begin
			left_reg <= {fall_cmd, 1'b0};
			ph_reg <= 1'b0;
		end else if (left_reg != 9'h000) begin
			ph_reg <= ~ph_reg;
			if (ph_reg) begin
				ext_line <= ~ext_line;
				left_reg <= left_reg - 9'h001;
			end
		end
	end
	assign busy = (left_reg != 9'h000);
endmodule : line_partner
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench of the counter array
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import counter_array_pkg::*;
	// ========================================
	// signals and bench model state
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	reg_req_t req = '0;
	logic [7:0] rd_data;
	logic global_irq_enable = 1'b1;
	logic array_irq_enable = 1'b1;
	logic cpu_idle = 1'b0;
	logic timer0_overflow = 1'b0;
	logic ext_line;
	logic [4:0] line_in, line_out, line_oe, line_drv;
	logic [4:0] level_cmd = 5'h00;
	logic [7:0] fall_cmd = 8'h00;
	logic fall_go = 1'b0;
	logic busy, irq_req, hit;
	logic [31:0] seed = 32'hCE9EB792;
	logic [7:0] b, d2;
	logic [15:0] v;
	logic [7:0] addrs [0:11] = '{8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD,
		8'hDE, 8'hE9, 8'hF9, 8'hEA, 8'hFA, 8'h00};
	logic [7:0] cap_modes [0:2] = '{8'h20, 8'h10, 8'h31};
	int fails = 0;
	int checked = 0;
	int cnt = 0;
	int live = 1;
	int capv = 0;
	int n;
	always #2 sys_clk = ~sys_clk;
	// the pin shows the design's drive where enabled, else the far side
	assign line_in = (line_oe & line_out) | (~line_oe & line_drv);
	counter_array counter_array_inst (.sys_clk(sys_clk), .rst(rst),
		.req(req), .rd_data(rd_data), .global_irq_enable(global_irq_enable),
		.array_irq_enable(array_irq_enable), .cpu_idle(cpu_idle),
		.timer0_overflow(timer0_overflow), .external_count_input(ext_line),
		.module_io_line_in(line_in), .module_io_line_out(line_out),
		.module_io_line_oe(line_oe), .irq_req(irq_req));
	line_partner line_partner_inst (.sys_clk(sys_clk), .rst(rst),
		.level_cmd(level_cmd), .fall_cmd(fall_cmd), .fall_go(fall_go),
		.line_drv(line_drv), .ext_line(ext_line), .busy(busy));
	// ========================================
	// tasks
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{addr: a, wr_data: d, wr_en: 1'b1, rd_en: 1'b0};
		@(posedge sys_clk);
		req.wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		req.addr <= a;
		req.rd_en <= 1'b1;
		@(posedge sys_clk);
		req.rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd
	// back-to-back reads: low byte, then the high byte it snapshotted
	task automatic get_cnt(output logic [15:0] c);
		@(posedge sys_clk);
		req.addr <= ADDR_CNT_LO;
		req.rd_en <= 1'b1;
		@(posedge sys_clk);
		req.addr <= ADDR_CNT_HI;
		#1;
		c[7:0] = rd_data;
		@(posedge sys_clk);
		req.rd_en <= 1'b0;
		#1;
		c[15:8] = rd_data;
	endtask : get_cnt
	// timer0 steps: held high for long runs, else one pulse per step
	task automatic tick(input int k, input logic hold);
		if (hold) begin
			@(posedge sys_clk);
			timer0_overflow <= 1'b1;
			repeat (k) @(posedge sys_clk);
			timer0_overflow <= 1'b0;
		end else begin
			repeat (k) begin
				@(posedge sys_clk);
				timer0_overflow <= 1'b1;
				@(posedge sys_clk);
				timer0_overflow <= 1'b0;
			end
		end
		cnt += k * live;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : tick
	initial begin
		repeat (95000) @(posedge sys_clk);
		fails++;
		give_verdict();
	end
	// ========================================
	// main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (addrs[i]) begin
			rd(addrs[i], b);
			chk(16'(b), 16'h0000);
		end
		$display("reset done");
		wr(ADDR_MODE, 8'h04);
		wr(ADDR_CTL, 8'h40);
		foreach (cap_modes[i]) begin
			wr(ADDR_CPM_BASE, cap_modes[i]);
			for (int e = 0; e < 2; e++) begin
				seed = lfsr(seed);
				tick(int'(seed[2:0]) + 1, 1'b0);
				@(posedge sys_clk);
				level_cmd <= {5{e == 0}};
				repeat (4) @(posedge sys_clk);
				hit = cap_modes[i][5 - e];
				if (hit) capv = cnt;
				rd(ADDR_CTL, b);
				chk(16'(b[4:0]), 16'(hit));
				rd(ADDR_CPL_BASE, v[7:0]);
				rd(ADDR_CPH_BASE, v[15:8]);
				chk(v, 16'(capv));
				wr(ADDR_CTL, 8'h40);
			end
		end
		chk(16'(line_oe), 16'h0000);
		$display("capture done");
		v = 16'(cnt + 5);
		for (int m = 1; m < 3; m++) begin
			wr(ADDR_CPL_BASE + 8'(m), v[7:0]);
			wr(ADDR_CPH_BASE + 8'(m), v[15:8]);
		end
		wr(ADDR_CPM_BASE + 8'h01, 8'h49);
		wr(ADDR_CPM_BASE + 8'h02, 8'h4C);
		tick(4, 1'b0);
		chk(16'({irq_req, line_out[2]}), 16'h0000);
		tick(1, 1'b0);
		chk(16'({line_oe[2], line_out[2]}), 16'h0003);
		rd(ADDR_CTL, b);
		chk(16'(b[4:0]), 16'h0006);
		for (int g = 0; g < 4; g++) begin
			@(posedge sys_clk);
			{global_irq_enable, array_irq_enable} <= 2'(g);
			repeat (3) @(posedge sys_clk);
			#1;
			chk(16'(irq_req), 16'(g == 3));
		end
		wr(ADDR_CPM_BASE + 8'h01, 8'h48);
		repeat (3) @(posedge sys_clk);
		#1;
		chk(16'(irq_req), 16'h0000);
		wr(ADDR_CTL, 8'h40);
		$display("compare done");
		seed = lfsr(seed);
		b = {seed[6:0], 1'b1};
		wr(ADDR_CPL_BASE + 8'h03, b);
		wr(ADDR_CPH_BASE + 8'h03, b);
		wr(ADDR_CPM_BASE + 8'h03, 8'h42);
		tick(((int'(b) - cnt - 1) & 255) + 1, 1'b0);
		chk(16'(line_out[3]), 16'h0001);
		// a duty change goes through the high byte only
		wr(ADDR_CPH_BASE + 8'h03, b ^ 8'h80);
		tick((256 - int'(b)) & 255, 1'b0);
		chk(16'(line_out[3]), 16'h0000);
		rd(ADDR_CPL_BASE + 8'h03, d2);
		chk(16'(d2), 16'(b ^ 8'h80));
		tick(int'(b ^ 8'h80), 1'b0);
		chk(16'(line_out[3]), 16'h0001);
		$display("pwm done");
		rd(ADDR_CNT_LO, b);
		v = 16'(cnt);
		tick(256, 1'b1);
		rd(ADDR_CNT_HI, d2);
		chk({d2, b}, v);
		get_cnt(v);
		chk(v, 16'(cnt));
		@(posedge sys_clk);
		cpu_idle <= 1'b1;
		wr(ADDR_MODE, 8'h84);
		live = 0;
		tick(4, 1'b0);
		get_cnt(v);
		chk(v, 16'(cnt));
		wr(ADDR_MODE, 8'h04);
		live = 1;
		tick(4, 1'b0);
		get_cnt(v);
		chk(v, 16'(cnt));
		@(posedge sys_clk);
		cpu_idle <= 1'b0;
		$display("idle done");
		wr(ADDR_CPM_BASE + 8'h01, 8'h00);
		wr(ADDR_CTL, 8'h40);
		wr(ADDR_MODE, 8'h05);
		tick(65536 - (cnt & 65535), 1'b1);
		rd(ADDR_CTL, b);
		chk(16'({irq_req, b[7:6]}), 16'h0007);
		wr(ADDR_MODE, 8'h04);
		rd(ADDR_CTL, b);
		chk(16'({irq_req, b[7]}), 16'h0001);
		wr(ADDR_CTL, 8'h00);
		rd(ADDR_CTL, b);
		chk(16'(b[7]), 16'h0000);
		live = 0;
		tick(5, 1'b0);
		get_cnt(v);
		chk(v, 16'(cnt));
		live = 1;
		$display("overflow done");
		wr(ADDR_CTL, 8'h40);
		for (int t = 0; t < 2; t++) begin
			wr(ADDR_MODE, {5'h00, 2'(t), 1'b0});
			rd(ADDR_CNT_LO, b);
			repeat (118) @(posedge sys_clk);
			rd(ADDR_CNT_LO, d2);
			chk(16'(8'(d2 - b)), (t == 1) ? 16'h001E : 16'h000A);
		end
		wr(ADDR_MODE, 8'h06);
		rd(ADDR_CNT_LO, b);
		@(posedge sys_clk);
		fall_cmd <= 8'h06;
		fall_go <= 1'b1;
		@(posedge sys_clk);
		fall_go <= 1'b0;
		#1;
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n < 100) begin
			repeat (4) @(posedge sys_clk);
			rd(ADDR_CNT_LO, d2);
			chk(16'(8'(d2 - b)), 16'h0006);
		end else begin
			fails++;
		end
		$display("timebase done");
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
